/* File: postld_pkg.sv */
`default_nettype none

package postld_pkg;

  // ----------------------------------------------------------------
  // host i/o write side
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CHECKPOINT_ADDR = 16'h0080;

  // ----------------------------------------------------------------
  // indicator layout
  // ----------------------------------------------------------------
  localparam int LED_COUNT = 4;
  localparam int RED_BASE = 4;
  localparam int GREEN_BASE = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CODE_RESET = 8'h00;
  localparam logic [LED_COUNT-1:0] LED_RESET = 4'h0;

  function automatic logic postld_is_checkpoint_write(
      input logic wr_strobe,
      input logic [ADDR_W-1:0] addr);
    return wr_strobe && (addr == CHECKPOINT_ADDR);
  endfunction

endpackage

`default_nettype wire

/* File: postld_code_if.sv */
`default_nettype none

interface postld_code_if;
  import postld_pkg::*;

  logic [DATA_W-1:0] code;
  logic loaded;

  modport src (
    output code,
    output loaded
  );

  modport dst (
    input code,
    input loaded
  );
endinterface

`default_nettype wire

/* File: postld_led_map.sv */
`default_nettype none

module postld_led_map (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // captured code
  postld_code_if.dst code_in,
  // indicator drive, active high
  output logic [postld_pkg::LED_COUNT-1:0] red_led,
  output logic [postld_pkg::LED_COUNT-1:0] green_led
);
  import postld_pkg::*;

  // ----------------------------------------------------------------
  // per-position drive
  // ----------------------------------------------------------------
  // registered so the pins never glitch while the code byte settles
  for (genvar i = 0; i < LED_COUNT; i++) begin : g_pos
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        red_led[i] <= 1'b0;
        green_led[i] <= 1'b0;
      end else begin
        red_led[i] <= code_in.code[RED_BASE+i];
        green_led[i] <= code_in.code[GREEN_BASE+i];
      end
    end

    amber_pos_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (code_in.code[RED_BASE+i] && code_in.code[GREEN_BASE+i])
        |=> (red_led[i] && green_led[i]))
      else $error("position not amber with both bits set");

    off_pos_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (!code_in.code[RED_BASE+i] && !code_in.code[GREEN_BASE+i])
        |=> (!red_led[i] && !green_led[i]))
      else $error("position lit with both bits clear");
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  red_nibble_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 red_led == $past(code_in.code[DATA_W-1:RED_BASE]))
    else $error("red elements do not follow upper nibble");

  green_nibble_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 green_led == $past(code_in.code[RED_BASE-1:GREEN_BASE]))
    else $error("green elements do not follow lower nibble");

  weight_pair_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 (red_led[LED_COUNT-1] == $past(code_in.code[DATA_W-1]))
      && (green_led[LED_COUNT-1] == $past(code_in.code[RED_BASE-1]))
      && (red_led[0] == $past(code_in.code[RED_BASE]))
      && (green_led[0] == $past(code_in.code[GREEN_BASE])))
    else $error("msb or lsb position paired wrongly");

  pos_independent_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (code_in.code == 8'h10) |=> (red_led == 4'h1) && (green_led == 4'h0))
    else $error("single red bit leaked to another element");

endmodule

`default_nettype wire

/* File: postld_decoder.sv */
`default_nettype none

module postld_decoder (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host i/o write, same clock domain
  input wire logic io_wr_strobe,
  input wire logic [postld_pkg::ADDR_W-1:0] io_addr,
  input wire logic [postld_pkg::DATA_W-1:0] io_wr_data,
  // indicators and captured code
  output logic [postld_pkg::LED_COUNT-1:0] red_led,
  output logic [postld_pkg::LED_COUNT-1:0] green_led,
  output logic [postld_pkg::DATA_W-1:0] checkpoint_code
);
  import postld_pkg::*;

  postld_code_if code_bus ();

  logic capture;

  // ----------------------------------------------------------------
  // checkpoint capture
  // ----------------------------------------------------------------
  // reads and other addresses are ignored; a stalled boot keeps its code
  assign capture = postld_is_checkpoint_write(io_wr_strobe, io_addr);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_bus.code <= CODE_RESET;
    end else if (capture) begin
      code_bus.code <= io_wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_bus.loaded <= 1'b0;
    end else if (capture) begin
      code_bus.loaded <= 1'b1;
    end
  end

  assign checkpoint_code = code_bus.code;

  // ----------------------------------------------------------------
  // led drive
  // ----------------------------------------------------------------
  postld_led_map u_map (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .code_in(code_bus.dst),
    .red_led(red_led),
    .green_led(green_led)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_checkpoint_write;
    postld_is_checkpoint_write(io_wr_strobe, io_addr);
  endsequence

  sequence s_other_write;
    io_wr_strobe && (io_addr != CHECKPOINT_ADDR);
  endsequence

  sequence s_no_write;
    !postld_is_checkpoint_write(io_wr_strobe, io_addr);
  endsequence

  // leds lag the write by the capture flop and the pin flop
  sequence s_shown;
    ##2 ({red_led, green_led} == $past(io_wr_data, 2));
  endsequence

  // with no write the code holds, so the pins hold one edge later
  sequence s_leds_held;
    ##2 ($stable(red_led) && $stable(green_led));
  endsequence

  capture_write_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_checkpoint_write |=> checkpoint_code == $past(io_wr_data))
    else $error("checkpoint write not captured");

  write_to_led_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_checkpoint_write |-> s_shown)
    else $error("written code not shown on indicators");

  hold_last_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !postld_is_checkpoint_write(io_wr_strobe, io_addr) |=> $stable(checkpoint_code))
    else $error("code changed without a checkpoint write");

  zero_before_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !code_bus.loaded |-> (checkpoint_code == CODE_RESET)
      && (red_led == LED_RESET) && (green_led == LED_RESET))
    else $error("indicators not dark before first write");

  other_addr_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_other_write |=> $stable(checkpoint_code))
    else $error("write to another address changed the code");

  last_wins_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_checkpoint_write ##1 s_checkpoint_write |=> checkpoint_code == $past(io_wr_data))
    else $error("later of two writes did not win");

  led_hold_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_no_write |-> s_leds_held)
    else $error("indicators changed without a checkpoint write");

  loaded_set_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_checkpoint_write |=> code_bus.loaded)
    else $error("first write not recorded");

  // ----------------------------------------------------------------
  // per-position checks
  // ----------------------------------------------------------------
  // each position must follow its own pair of written bits
  for (genvar p = 0; p < LED_COUNT; p++) begin : g_chk
    pos_pair_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      s_checkpoint_write |-> ##2 (red_led[p] == $past(io_wr_data[RED_BASE+p], 2))
        && (green_led[p] == $past(io_wr_data[GREEN_BASE+p], 2)))
      else $error("position pair does not follow the written bits");
  end

endmodule

`default_nettype wire

/* File: postld_host.sv */
`default_nettype none

module postld_host (
  // clock
  input wire logic ref_clk,
  // host i/o write
  output logic io_wr_strobe,
  output logic [postld_pkg::ADDR_W-1:0] io_addr,
  output logic [postld_pkg::DATA_W-1:0] io_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import postld_pkg::*;

  // ------------------------------------
  // write cycles
  // ------------------------------------
  initial begin
    io_wr_strobe = 1'b0;
    io_addr = 16'h0000;
    io_wr_data = 8'h00;
  end

  // held to the next edge; calls may follow back to back
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    io_wr_strobe <= 1'b1;
    io_addr <= a;
    io_wr_data <= d;
    @(posedge ref_clk);
  endtask

  // released bus shows inverted values, not the last ones
  task automatic idle();
    io_wr_strobe <= 1'b0;
    io_addr <= ~io_addr;
    io_wr_data <= ~io_wr_data;
  endtask
endmodule

`default_nettype wire

/* File: test_post_code_led_decoder.sv */
`default_nettype none

module test_post_code_led_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import postld_pkg::*;

  // ------------------------------------
  // harness
  // ------------------------------------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic io_wr_strobe;
  logic [ADDR_W-1:0] io_addr;
  logic [DATA_W-1:0] io_wr_data;
  logic [LED_COUNT-1:0] red_led;
  logic [LED_COUNT-1:0] green_led;
  logic [DATA_W-1:0] checkpoint_code;
  int err_count = 0;
  int checks_done = 0;

  always #12.5 ref_clk = ~ref_clk;

  postld_host host_u (.ref_clk(ref_clk), .io_wr_strobe(io_wr_strobe), .io_addr(io_addr),
    .io_wr_data(io_wr_data));
  postld_decoder dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .io_wr_strobe(io_wr_strobe),
    .io_addr(io_addr), .io_wr_data(io_wr_data), .red_led(red_led), .green_led(green_led),
    .checkpoint_code(checkpoint_code));

  // ------------------------------------
  // helpers
  // ------------------------------------
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // leds settle two edges after the accepted write
  task automatic show(input logic [7:0] d, input logic [7:0] e);
    @(posedge ref_clk);
    host_u.put(CHECKPOINT_ADDR, d);
    host_u.idle();
    repeat (2) @(posedge ref_clk);
    #1;
    chk(e, checkpoint_code);
    chk(e, {red_led, green_led});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic test_codes();
    logic [7:0] tbl[6] = '{8'hac, 8'hff, 8'h00, 8'h5a, 8'h81, 8'h10};
    foreach (tbl[i]) show(tbl[i], tbl[i]);
    $display("test codes done");
  endtask

  task automatic test_hold();
    show(8'h3c, 8'h3c);
    @(posedge ref_clk);
    host_u.put(16'h0081, 8'hc3);
    host_u.put(16'h0180, 8'hc3);
    host_u.idle();
    repeat (2) @(posedge ref_clk);
    #1;
    chk(8'h3c, checkpoint_code);
    chk(8'h3c, {red_led, green_led});
    @(posedge ref_clk);
    host_u.put(CHECKPOINT_ADDR, 8'h11);
    host_u.put(CHECKPOINT_ADDR, 8'h22); // back to back, last wins
    host_u.idle();
    repeat (4) @(posedge ref_clk);
    #1;
    chk(8'h22, {red_led, green_led});
    $display("test hold done");
  endtask

  task automatic test_reset();
    #1;
    chk(8'h00, {red_led, green_led});
    chk(8'h00, checkpoint_code);
    show(8'hff, 8'hff);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    #5;
    chk(8'h00, {red_led, green_led});
    chk(8'h00, checkpoint_code);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    $display("test reset done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    test_reset();
    test_codes();
    test_hold();
    conclude();
  end

  // hang guard
  initial begin
    #100us;
    err_count++;
    conclude();
  end
endmodule

`default_nettype wire
